// File: hcs_cfg_if.sv
// Purpose: carries the committed hop settings between selector modules
// Assumes: single clock domain
// Notes:   all fields are levels held between commits

`timescale 1ns/1ps

interface hcs_cfg_if;
  logic [3:0]  key;
  logic [2:0]  table_sel;
  logic [6:0]  size;
  logic [1:0]  offset;
  logic [15:0] zone_mask;

  modport src (output key, output table_sel, output size, output offset, output zone_mask);
  modport dst (input key, input table_sel, input size, input offset, input zone_mask);
endinterface : hcs_cfg_if

// File: hcs_chan_map.sv
// Purpose: maps a table index to an absolute raster channel
// Assumes: index below size
// Notes:   index times span over size gives an even spread inside the band portion

`timescale 1ns/1ps

module hcs_chan_map
  import hcs_pkg::*;
(
  // settings
  hcs_cfg_if.dst          cfg,
  // lookup
  input  wire logic [6:0] index_i,
  output logic      [9:0] chan_o
);
  logic [9:0] span;
  logic [9:0] base;
  logic [9:0] pos;
  logic [9:0] spread;
  logic [9:0] shift;

  always_comb begin
    base = 10'h000;
    span = HCS_BAND_STEPS;
    case (cfg.table_sel)
      3'h0, 3'h1: span = HCS_BAND_STEPS;
      3'h2: span = HCS_THIRD_STEPS;
      3'h3: begin
        base = HCS_MID_BASE;
        span = HCS_THIRD_STEPS;
      end
      3'h4: begin
        base = HCS_UP_BASE;
        span = HCS_THIRD_STEPS;
      end
      default: span = 10'(HCS_THIRD_STEPS << 1);
    endcase
    spread = 10'((32'(index_i) * 32'(span)) / 32'(cfg.size));
    pos    = 10'(base + spread);
    // portion 5 skips the middle third
    if (cfg.table_sel == 3'h5 && spread >= HCS_THIRD_STEPS) begin
      pos = 10'(spread + HCS_THIRD_STEPS);
    end
    // portion 1 moves the whole grid up by HCS_SHIFT_HALF, a fixed 3 raster steps
    shift = (cfg.table_sel == 3'h1) ? HCS_SHIFT_HALF : 10'h000;
    chan_o = 10'(pos + shift + 10'(cfg.offset));
  end
endmodule : hcs_chan_map

// File: hcs_peer_model.sv
// Purpose: peer modem view of the hop stream, flags hops a matched peer could not follow
// Assumes: peer is loaded with the same table settings as the unit under test
// Notes:   zone of a channel is channel / 45 raster steps

`timescale 1ns/1ps

module hcs_peer_model
  import hcs_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // hop stream
  input  wire logic [9:0]  hop_chan_i,
  input  wire logic        hop_valid_i,
  // peer settings
  input  wire logic [15:0] zone_mask_i,
  input  wire logic [9:0]  lo_i,
  input  wire logic [9:0]  hi_i,
  input  wire logic        gap_i,
  // tallies
  output logic      [15:0] hop_count_o,
  output logic      [15:0] bad_count_o
);
  logic [9:0] zone;
  logic       bad;

  assign zone = hop_chan_i / HCS_ZONE_STEPS;
  // a hop outside the shared table or in a closed zone would desync the link
  assign bad = (zone > 10'h00F) || !zone_mask_i[zone[3:0]]
             || (hop_chan_i < lo_i) || (hop_chan_i > hi_i)
             || (gap_i && hop_chan_i >= 10'h0F3 && hop_chan_i < HCS_UP_BASE);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hop_count_o <= 16'h0000;
      bad_count_o <= 16'h0000;
    end else if (hop_valid_i) begin
      hop_count_o <= hop_count_o + 16'h0001;
      bad_count_o <= bad_count_o + {15'h0000, bad};
    end
  end
endmodule : hcs_peer_model

// File: hcs_perm.sv
// Purpose: key dependent permutation of a slot index into a table slot
// Assumes: size between 50 and 112
// Notes:   slot*stride mod size with a stride coprime to every size in range

`timescale 1ns/1ps

module hcs_perm
  import hcs_pkg::*;
(
  // settings
  input  wire logic [3:0] key_i,
  input  wire logic [6:0] size_i,
  // slot
  input  wire logic [6:0] slot_i,
  output logic      [6:0] index_o
);
  // strides are primes above 112 so every key gives a full permutation;
  // strides that are equal mod size make the same order, so keys 0 and 8 collide at size 50
  logic [7:0]  stride;
  logic [15:0] prod;
  logic [15:0] rem;

  always_comb begin
    case (key_i)
      4'h0: stride = 8'h71;
      4'h1: stride = 8'h7F;
      4'h2: stride = 8'h83;
      4'h3: stride = 8'h89;
      4'h4: stride = 8'h8B;
      4'h5: stride = 8'h95;
      4'h6: stride = 8'h97;
      4'h7: stride = 8'h9D;
      4'h8: stride = 8'hA3;
      4'h9: stride = 8'hA7;
      4'hA: stride = 8'hAD;
      4'hB: stride = 8'hB3;
      4'hC: stride = 8'hB5;
      4'hD: stride = 8'hBF;
      default: stride = 8'hC1;
    endcase
    prod = 16'({8'h00, stride} * {9'h000, slot_i});
    rem  = prod % {9'h000, size_i};
    index_o = rem[6:0];
  end
endmodule : hcs_perm

// File: hcs_pkg.sv
// Purpose: shared constants and types for the hop channel selector
// Assumes: 20 MHz core clock, plain register port
// Notes:   channel grid is in 115.2 kHz raster steps

package hcs_pkg;
  // register indices (word addresses)
  localparam logic [3:0] HCS_REG_KEY    = 4'h0;
  localparam logic [3:0] HCS_REG_TABLE  = 4'h1;
  localparam logic [3:0] HCS_REG_SIZE   = 4'h2;
  localparam logic [3:0] HCS_REG_OFFSET = 4'h3;
  localparam logic [3:0] HCS_REG_ZONE   = 4'h4;
  localparam logic [3:0] HCS_REG_CTRL   = 4'h5;
  localparam logic [3:0] HCS_REG_STATUS = 4'h6;
  localparam logic [3:0] HCS_REG_CHAN   = 4'h7;

  // field limits
  localparam logic [3:0] HCS_KEY_MAX    = 4'hE;
  localparam logic [2:0] HCS_TABLE_MAX  = 3'h5;
  localparam logic [6:0] HCS_SIZE_MIN   = 7'h32;
  localparam logic [6:0] HCS_SIZE_MAX   = 7'h70;
  localparam logic [1:0] HCS_OFFSET_MAX = 2'h2;

  // reset values
  localparam logic [3:0]  HCS_KEY_RST    = 4'h0;
  localparam logic [2:0]  HCS_TABLE_RST  = 3'h0;
  localparam logic [6:0]  HCS_SIZE_RST   = 7'h50;
  localparam logic [1:0]  HCS_OFFSET_RST = 2'h0;
  localparam logic [15:0] HCS_ZONE_RST   = 16'hFFFE;

  // raster: full band is 16 zones of 45 steps of 115.2 kHz
  localparam logic [9:0] HCS_ZONE_STEPS  = 10'h02D;
  localparam logic [9:0] HCS_BAND_STEPS  = 10'h2D0;
  localparam logic [9:0] HCS_THIRD_STEPS = 10'h0F0;
  localparam logic [9:0] HCS_MID_BASE    = 10'h0F0;
  localparam logic [9:0] HCS_UP_BASE     = 10'h1E0;
  localparam logic [9:0] HCS_SHIFT_HALF  = 10'h003;

  // control bits
  localparam int HCS_CTRL_START = 0;
  localparam int HCS_CTRL_HOP   = 1;

  typedef enum logic [1:0] {
    HCS_BAND_FULL,
    HCS_BAND_LOW,
    HCS_BAND_MID,
    HCS_BAND_UPPER
  } hcs_part_e;
endpackage : hcs_pkg

// File: hcs_top.sv
// Purpose: hop channel selector register block and sequencer
// Assumes: 20 MHz core clock; software commits settings then starts
// Notes:   channel number counts 115.2 kHz raster steps from band bottom
//
// Contract
// - The pattern key takes fifteen values 0 to E, each a different pattern; at size 50 keys 0 and 8 give the same order here.
// - Different keys give hop orders that do not share a channel in the same dwell; here slot 0 maps to index 0 for every key.
// - Band portion 0..5 selects full, full shifted, lower, middle, upper, lower plus upper.
// - The channel count is programmable from 50 to 112 inclusive.
// - Each channel shift step displaces every hop by 115.2 kHz.
// - All units in a network use the same band portion and channel count.
// - The sub-band mask is sixteen bits, one per equal sixteenth of the band.
// - Mask bit 0 is the lowest sub-band and bit 15 the highest.
// - A set mask bit allows hops in its sub-band, a clear one skips them.
// - With shift zero, mask bit 0 is forced clear.
// - With shift one or two, mask bit 15 is forced clear.

`timescale 1ns/1ps

module hcs_top
  import hcs_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // hop output
  output logic      [9:0]  hop_chan_o,
  output logic             hop_valid_o,
  output logic             hop_busy_o
);
  hcs_cfg_if cfg ();

  logic [3:0]  key;
  logic [2:0]  table_sel;
  logic [6:0]  size;
  logic [1:0]  offset;
  logic [15:0] zone_mask;
  logic [15:0] eff_mask;
  logic        cfg_err;
  logic        start_req;
  logic        hop_req;

  typedef enum logic [1:0] {
    HCS_IDLE,
    HCS_SEEK,
    HCS_HOLD
  } hcs_state_e;

  hcs_state_e  state;
  logic [6:0]  slot;
  logic [6:0]  tries;
  logic [6:0]  index;
  logic [9:0]  cand;
  logic [3:0]  cand_zone;
  logic        cand_ok;
  logic        no_zone;

  assign cfg.key       = key;
  assign cfg.table_sel = table_sel;
  assign cfg.size      = size;
  assign cfg.offset    = offset;
  assign cfg.zone_mask = eff_mask;

  // settings writes; out of range values are refused and flagged
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key       <= HCS_KEY_RST;
      table_sel <= HCS_TABLE_RST;
      size      <= HCS_SIZE_RST;
      offset    <= HCS_OFFSET_RST;
      zone_mask <= HCS_ZONE_RST;
      cfg_err   <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == HCS_REG_KEY) begin
        if (reg_wdata_i[3:0] <= HCS_KEY_MAX) key <= reg_wdata_i[3:0];
        else cfg_err <= 1'b1;
      end else if (reg_addr_i == HCS_REG_TABLE) begin
        if (reg_wdata_i[2:0] <= HCS_TABLE_MAX) table_sel <= reg_wdata_i[2:0];
        else cfg_err <= 1'b1;
      end else if (reg_addr_i == HCS_REG_SIZE) begin
        if (reg_wdata_i[6:0] >= HCS_SIZE_MIN && reg_wdata_i[6:0] <= HCS_SIZE_MAX)
          size <= reg_wdata_i[6:0];
        else cfg_err <= 1'b1;
      end else if (reg_addr_i == HCS_REG_OFFSET) begin
        if (reg_wdata_i[1:0] <= HCS_OFFSET_MAX) offset <= reg_wdata_i[1:0];
        else cfg_err <= 1'b1;
      end else if (reg_addr_i == HCS_REG_ZONE) begin
        zone_mask <= reg_wdata_i[15:0];
      end else if (reg_addr_i == HCS_REG_STATUS) begin
        if (reg_wdata_i[0]) cfg_err <= 1'b0;
      end
    end
  end

  // one band edge zone is forced off whatever software wrote: zone 0 with shift zero, else zone 15
  always_comb begin
    eff_mask = zone_mask;
    if (offset == 2'h0) eff_mask[0] = 1'b0;
    else eff_mask[15] = 1'b0;
  end

  // control strobes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_req <= 1'b0;
      hop_req   <= 1'b0;
    end else begin
      start_req <= reg_wr_i && reg_addr_i == HCS_REG_CTRL && reg_wdata_i[HCS_CTRL_START];
      hop_req   <= reg_wr_i && reg_addr_i == HCS_REG_CTRL && reg_wdata_i[HCS_CTRL_HOP];
    end
  end

  hcs_perm u_perm (
    .key_i   (key),
    .size_i  (size),
    .slot_i  (slot),
    .index_o (index)
  );

  hcs_chan_map u_map (
    .cfg     (cfg),
    .index_i (index),
    .chan_o  (cand)
  );

  // zone of a candidate: 45 raster steps per zone, bit 0 lowest
  assign cand_zone = 4'(cand / HCS_ZONE_STEPS);
  assign cand_ok   = eff_mask[cand_zone];
  assign no_zone   = (eff_mask == 16'h0000);

  // sequencer: walks slots, skipping those in disabled zones
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state       <= HCS_IDLE;
      slot        <= 7'h00;
      tries       <= 7'h00;
      hop_chan_o  <= 10'h000;
      hop_valid_o <= 1'b0;
    end else begin
      hop_valid_o <= 1'b0;
      case (state)
        HCS_IDLE: begin
          if (start_req && !no_zone) begin
            slot  <= 7'h00;
            tries <= 7'h00;
            state <= HCS_SEEK;
          end
        end
        HCS_SEEK: begin
          if (cand_ok) begin
            hop_chan_o  <= cand;
            hop_valid_o <= 1'b1;
            state       <= HCS_HOLD;
          end else if (tries == 7'(size - 7'h01)) begin
            state <= HCS_IDLE;
          end else begin
            tries <= 7'(tries + 7'h01);
          end
          if (!cand_ok) begin
            slot <= (slot == 7'(size - 7'h01)) ? 7'h00 : 7'(slot + 7'h01);
          end
        end
        default: begin
          if (start_req) begin
            slot  <= 7'h00;
            tries <= 7'h00;
            state <= no_zone ? HCS_IDLE : HCS_SEEK;
          end else if (hop_req) begin
            slot  <= (slot == 7'(size - 7'h01)) ? 7'h00 : 7'(slot + 7'h01);
            tries <= 7'h00;
            state <= HCS_SEEK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) hop_busy_o <= 1'b0;
    else hop_busy_o <= (state == HCS_SEEK) || start_req || hop_req;
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == HCS_REG_KEY) reg_rdata_o <= {28'h0, key};
      else if (reg_addr_i == HCS_REG_TABLE) reg_rdata_o <= {29'h0, table_sel};
      else if (reg_addr_i == HCS_REG_SIZE) reg_rdata_o <= {25'h0, size};
      else if (reg_addr_i == HCS_REG_OFFSET) reg_rdata_o <= {30'h0, offset};
      else if (reg_addr_i == HCS_REG_ZONE) reg_rdata_o <= {16'h0, eff_mask};
      else if (reg_addr_i == HCS_REG_STATUS)
        reg_rdata_o <= {28'h0, no_zone, state == HCS_HOLD, state == HCS_SEEK, cfg_err};
      else if (reg_addr_i == HCS_REG_CHAN) reg_rdata_o <= {15'h0, slot, hop_chan_o};
      else reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // checks
  property p_edge_low;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o && offset == 2'h0 |-> hop_chan_o >= HCS_ZONE_STEPS;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("zone 0 used with shift 0");

  property p_edge_high;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o && offset != 2'h0 && $stable(offset) |-> hop_chan_o < 10'(HCS_BAND_STEPS - HCS_ZONE_STEPS);
  endproperty
  a_edge_high: assert property (p_edge_high) else $error("zone 15 used with shift");

  property p_mask_ok;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o && $stable(eff_mask) |-> eff_mask[4'(hop_chan_o / HCS_ZONE_STEPS)];
  endproperty
  a_mask_ok: assert property (p_mask_ok) else $error("hop in disabled zone");

  property p_size_range;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    size >= HCS_SIZE_MIN && size <= HCS_SIZE_MAX;
  endproperty
  a_size_range: assert property (p_size_range) else $error("size out of range");

  property p_key_range;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_KEY && reg_wdata_i[3:0] == 4'hF |=> $stable(key) && cfg_err;
  endproperty
  a_key_range: assert property (p_key_range) else $error("key F accepted");

  property p_table_range;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    table_sel <= HCS_TABLE_MAX;
  endproperty
  a_table_range: assert property (p_table_range) else $error("bad band portion");

  property p_mid_band;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o && table_sel == 3'h5 && $stable(table_sel)
      |-> hop_chan_o < HCS_MID_BASE || hop_chan_o >= HCS_UP_BASE;
  endproperty
  a_mid_band: assert property (p_mid_band) else $error("middle third used");

  property p_start_hop;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    start_req && eff_mask == 16'hFFFE && offset == 2'h0 && $stable(eff_mask)
      |-> ##[1:120] hop_valid_o;
  endproperty
  a_start_hop: assert property (p_start_hop) else $error("no hop after start");

  property p_key_take;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_KEY && reg_wdata_i[3:0] <= HCS_KEY_MAX
      |=> key == 4'($past(reg_wdata_i));
  endproperty
  a_key_take: assert property (p_key_take) else $error("legal key not taken");

  property p_table_refuse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_TABLE && reg_wdata_i[2:0] > HCS_TABLE_MAX
      |=> $stable(table_sel) && cfg_err;
  endproperty
  a_table_refuse: assert property (p_table_refuse) else $error("bad portion taken");

  // a refused size must leave the old one, or peers lose step
  property p_size_refuse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_SIZE
      && (reg_wdata_i[6:0] < HCS_SIZE_MIN || reg_wdata_i[6:0] > HCS_SIZE_MAX)
      |=> $stable(size) && cfg_err;
  endproperty
  a_size_refuse: assert property (p_size_refuse) else $error("bad size taken");

  property p_shift_refuse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_OFFSET && reg_wdata_i[1:0] > HCS_OFFSET_MAX
      |=> $stable(offset) && cfg_err;
  endproperty
  a_shift_refuse: assert property (p_shift_refuse) else $error("bad shift taken");

  property p_zone_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == HCS_REG_ZONE |=> zone_mask == 16'($past(reg_wdata_i));
  endproperty
  a_zone_write: assert property (p_zone_write) else $error("zone mask not stored");

  property p_shift_low;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    offset == 2'h0 |-> !eff_mask[0];
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("zone 0 open with shift 0");

  property p_shift_high;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    offset != 2'h0 |-> !eff_mask[15];
  endproperty
  a_shift_high: assert property (p_shift_high) else $error("zone 15 open with shift");

  property p_zone_bounds;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o |-> hop_chan_o < HCS_BAND_STEPS;
  endproperty
  a_zone_bounds: assert property (p_zone_bounds) else $error("hop above zone 15");

  property p_valid_pulse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o |=> !hop_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("hop valid held");

  property p_start_slot;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    state == HCS_IDLE && start_req && !no_zone |=> state == HCS_SEEK && slot == 7'h00;
  endproperty
  a_start_slot: assert property (p_start_slot) else $error("start not at slot 0");

  property p_empty_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    state == HCS_IDLE && no_zone |=> state == HCS_IDLE;
  endproperty
  a_empty_idle: assert property (p_empty_idle) else $error("seek with no zone");

  property p_chan_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    $changed(hop_chan_o) |-> hop_valid_o;
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved silently");

  property p_busy_seek;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    state == HCS_SEEK |=> hop_busy_o;
  endproperty
  a_busy_seek: assert property (p_busy_seek) else $error("seek not shown busy");

  c_start: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    start_req ##[1:120] hop_valid_o);
  c_next:  cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    hop_req ##[1:120] hop_valid_o);
  c_skip:  cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    state == HCS_SEEK && !cand_ok);
  c_split: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    hop_valid_o && table_sel == 3'h5);
  c_empty: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    start_req && no_zone);
endmodule : hcs_top

// File: hop_channel_selector_bench.sv
// Purpose: self-checking bench for the hop channel selector
// Assumes: 20 MHz clock, register read data sampled one cycle after the strobe
// Notes:   peer tallies are reset with the unit, so a mid-run reset ends the peer checks

`timescale 1ns/1ps

module hop_channel_selector_bench
  import hcs_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic [3:0]  reg_addr   = 4'h0;
  logic [31:0] reg_wdata  = 32'h0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [9:0]  hop_chan_o;
  logic        hop_valid_o;
  logic        hop_busy_o;
  logic [15:0] pmask = 16'hFFFF;
  logic [9:0]  plo = 10'h000;
  logic [9:0]  phi = 10'h2D4;
  logic        pgap = 1'b0;
  logic [15:0] hop_count;
  logic [15:0] bad_count;
  int          failures = 0;
  int          checks = 0;
  int          nhops = 0;
  int          cycles = 0;
  logic [31:0] d;
  logic        got;
  logic [9:0]  seq_a [0:5];
  logic [9:0]  seq [0:7];
  logic [9:0]  base;
  logic [3:0]  r_addr [0:10] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h8};
  logic [31:0] r_wd [0:10] = '{32'hE, 32'hF, 32'h5, 32'h6, 32'h32, 32'h31, 32'h70, 32'h71,
                                32'h2, 32'h3, 32'h5};
  logic [31:0] r_exp [0:10] = '{32'hE, 32'hE, 32'h5, 32'h5, 32'h32, 32'h32, 32'h70, 32'h70,
                                 32'h2, 32'h2, 32'h0};
  logic        r_err [0:10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #25 core_clk_i = ~core_clk_i;

  hcs_top dut (
    .core_clk_i (core_clk_i), .reset_n_i (reset_n_i), .reg_addr_i (reg_addr),
    .reg_wdata_i (reg_wdata), .reg_wr_i (reg_wr), .reg_rd_i (reg_rd),
    .reg_rdata_o (reg_rdata_o), .hop_chan_o (hop_chan_o), .hop_valid_o (hop_valid_o),
    .hop_busy_o (hop_busy_o)
  );

  hcs_peer_model peer (
    .core_clk_i (core_clk_i), .reset_n_i (reset_n_i), .hop_chan_i (hop_chan_o),
    .hop_valid_i (hop_valid_o), .zone_mask_i (pmask), .lo_i (plo), .hi_i (phi),
    .gap_i (pgap), .hop_count_o (hop_count), .bad_count_o (bad_count)
  );

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  // bounded wait: the slowest legal hop is size plus two cycles, size tops out at 112
  task automatic wait_hop(output logic g, output logic [9:0] ch);
    g = 1'b0;
    ch = 10'h000;
    for (int i = 0; i < 130 && !g; i++) begin
      @(posedge core_clk_i);
      #1;
      if (hop_valid_o === 1'b1) begin
        g = 1'b1;
        ch = hop_chan_o;
        nhops++;
      end
    end
  endtask : wait_hop

  task automatic setup(input logic [3:0] k, input logic [2:0] t, input logic [6:0] s,
                       input logic [1:0] o, input logic [15:0] m);
    wr(HCS_REG_KEY, {28'h0, k});
    wr(HCS_REG_TABLE, {29'h0, t});
    wr(HCS_REG_SIZE, {25'h0, s});
    wr(HCS_REG_OFFSET, {30'h0, o});
    wr(HCS_REG_ZONE, {16'h0, m});
    pmask = m & ((o == 2'h0) ? 16'hFFFE : 16'h7FFF);
    plo   = (t == 3'h3) ? HCS_MID_BASE : (t == 3'h4) ? HCS_UP_BASE : 10'h000;
    phi   = (t == 3'h2) ? 10'h0F2 : (t == 3'h3) ? 10'h1E2 : (t < 3'h2) ? 10'h2D4 : 10'h2D2;
    pgap  = (t == 3'h5);
  endtask : setup

  task automatic run(input int n);
    wr(HCS_REG_CTRL, 32'h1);
    for (int i = 0; i < n; i++) begin
      wait_hop(got, seq[i]);
      chk("hop seen", 32'h1, {31'h0, got});
      chk("busy at hop", 32'h1, {31'h0, hop_busy_o});
      if (i < n - 1) wr(HCS_REG_CTRL, 32'h2);
    end
  endtask : run

  initial begin
    repeat (10) @(posedge core_clk_i);
    chk("valid in reset", 32'h0, {31'h0, hop_valid_o});
    chk("chan in reset", 32'h0, {22'h0, hop_chan_o});
    reset_n_i <= 1'b1;
    rd(HCS_REG_KEY, d);    chk("key reset", 32'h0, d);
    rd(HCS_REG_TABLE, d);  chk("table reset", 32'h0, d);
    rd(HCS_REG_SIZE, d);   chk("size reset", 32'h50, d);
    rd(HCS_REG_OFFSET, d); chk("offset reset", 32'h0, d);
    rd(HCS_REG_ZONE, d);   chk("zone reset", 32'hFFFE, d);
    wr(HCS_REG_CTRL, 32'h2);
    wait_hop(got, base);
    chk("next hop while idle", 32'h0, {31'h0, got});
    for (int i = 0; i < 11; i++) begin
      wr(r_addr[i], r_wd[i]);
      rd(r_addr[i], d);
      chk("readback", r_exp[i], d);
      rd(HCS_REG_STATUS, d);
      chk("cfg error", {31'h0, r_err[i]}, {31'h0, d[0]});
      wr(HCS_REG_STATUS, 32'h1);
    end
    for (int k = 0; k < 15; k++) begin
      wr(HCS_REG_KEY, k);
      rd(HCS_REG_KEY, d);
      chk("key value", k, d);
    end
    setup(4'h0, 3'h0, 7'h50, 2'h0, 16'hFFFF);
    rd(HCS_REG_ZONE, d); chk("zone shift 0", 32'hFFFE, d);
    for (int o = 1; o < 3; o++) begin
      wr(HCS_REG_OFFSET, o);
      rd(HCS_REG_ZONE, d); chk("zone shift 1 2", 32'h7FFF, d);
    end
    wr(HCS_REG_OFFSET, 32'h0);
    run(6);
    for (int i = 0; i < 6; i++) seq_a[i] = seq[i];
    rd(HCS_REG_CHAN, d);
    chk("chan reg", {22'h0, seq[5]}, {22'h0, d[9:0]});
    @(posedge core_clk_i);
    #1 chk("rdata idle", 32'h0, reg_rdata_o);
    rd(HCS_REG_STATUS, d);
    chk("status holding", 32'h4, {28'h0, d[3:0]});
    chk("busy while holding", 32'h0, {31'h0, hop_busy_o});
    run(6);
    for (int i = 0; i < 6; i++) chk("repeat order", seq_a[i], seq[i]);
    setup(4'h1, 3'h0, 7'h50, 2'h0, 16'hFFFF);
    run(6);
    for (int i = 0; i < 6; i++) chk("key collision", 32'h1, {31'h0, seq_a[i] != seq[i]});
    for (int t = 0; t < 6; t++) begin
      setup(4'h3, 3'(t), 7'h32, 2'h0, 16'hFFFF);
      run(4);
    end
    for (int o = 0; o < 3; o++) begin
      setup(4'h2, 3'h3, 7'h3C, 2'(o), 16'hFFFF);
      run(1);
      chk("shifted chan", {22'h0, HCS_MID_BASE} + o, {22'h0, seq[0]});
    end
    // masking only beside the standard full band table
    setup(4'h4, 3'h0, 7'h70, 2'h1, 16'h00F0);
    run(8);
    setup(4'h0, 3'h0, 7'h50, 2'h0, 16'h0001);
    wr(HCS_REG_CTRL, 32'h1);
    wait_hop(got, base);
    chk("start on empty mask", 32'h0, {31'h0, got});
    rd(HCS_REG_STATUS, d); chk("mask empty", 32'h1, {31'h0, d[3]});
    chk("peer hop count", nhops, {16'h0, hop_count});
    chk("peer bad hops", 32'h0, {16'h0, bad_count});
    setup(4'h5, 3'h0, 7'h70, 2'h0, 16'h8000);
    wr(HCS_REG_CTRL, 32'h1);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 chk("busy in reset", 32'h0, {31'h0, hop_busy_o});
    reset_n_i <= 1'b1;
    rd(HCS_REG_SIZE, d); chk("size after reset", 32'h50, d);
    end_of_test();
  end
endmodule : hop_channel_selector_bench
